// ---- dv/htc_host.sv ----
// host i2c controller model: open-drain pins stepped at core clock falling edges
`timescale 1ns/1ns
module htc_host (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	int maxst = 0;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic q();
		@(negedge clk);
	endtask : q
	// bounded, so a target stuck low cannot hang the run
	task automatic hi();
		int n;
		n = 0;
		scl_oe = 1'b0;
		q();
		while (scl !== 1'b1 && n < 5000) begin
			n++;
			q();
		end
		if (n > maxst) maxst = n;
	endtask : hi
	task automatic start();
		sda_oe = 1'b0;
		q();
		hi();
		sda_oe = 1'b1;
		q();
		scl_oe = 1'b1;
		q();
	endtask : start
	task automatic stop();
		sda_oe = 1'b1;
		q();
		hi();
		sda_oe = 1'b0;
		q();
	endtask : stop
	// sda only moves while scl is low
	task automatic bit1(input logic b, output logic r);
		sda_oe = ~b;
		q();
		hi();
		r = sda;
		q();
		scl_oe = 1'b1;
		q();
	endtask : bit1
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(b[i], r);
		bit1(1'b1, ack);
		ack = ~ack;
	endtask : wbyte
	// ack while more bytes are wanted, nack the last one
	task automatic rbyte(output logic [7:0] d, input logic more);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
		bit1(~more, r);
	endtask : rbyte
endmodule : htc_host

// ---- dv/htc_top_tb.sv ----
// self-checking bench of the sensor command port driven by the host model
`timescale 1ns/1ns
module htc_top_tb;
	localparam int NC = 300;
	localparam int FC = 120;
	localparam logic [31:0] SA = 32'hA1B2C3D4; // arbitrary
	localparam logic [31:0] SB = 32'h5E6F7081; // arbitrary
	localparam logic [23:0] QR = 24'h3C5A96; // arbitrary
	localparam logic [7:0] FF = htc_pkg::IDLE_BYTE;
	typedef struct packed {
		logic [15:0] c;
		logic hold;
		logic fast;
		logic [15:0] t;
		logic [15:0] h;
	} htc_mrow_t;
	logic REF_CLK = 1'b0;
	logic LINK_CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [15:0] TEMP_CODE = 16'h0000;
	logic [15:0] HUM_CODE = 16'h0000;
	logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, HEATER_EN, CONV_BUSY, CONV_FAST;
	logic [3:0] HEATER_LEVEL;
	logic h_scl_oe, h_sda_oe, a;
	logic [63:0] e;
	int w;
	int num_errors = 0;
	int n_compared = 0;
	// pull-ups: a released line floats high
	wire scl = (SCL_OE ? SCL_OUT : 1'b1) & ~h_scl_oe;
	wire sda = (SDA_OE ? SDA_OUT : 1'b1) & ~h_sda_oe;
	// written byte, heater bit, level, byte read back
	logic [20:0] ht[5] = '{{8'h15, 1'b1, 4'h5, 8'h15}, {8'h0F, 1'b0, 4'hF, 8'h0F},
		{8'h10, 1'b1, 4'h0, 8'h10}, {8'hFF, 1'b1, 4'hF, 8'h1F}, {8'hE0, 1'b0, 4'h0, 8'h00}};
	htc_mrow_t mt[4] = '{
		'{{htc_pkg::CMD_NH0, htc_pkg::CMD_NH1}, 1'b1, 1'b0, 16'h6A5C, 16'h8001},
		'{{htc_pkg::CMD_NN0, htc_pkg::CMD_NN1}, 1'b0, 1'b0, 16'hFFFF, 16'h0000},
		'{{htc_pkg::CMD_FH0, htc_pkg::CMD_FH1}, 1'b1, 1'b1, 16'h0001, 16'hFFFE},
		'{{htc_pkg::CMD_FN0, htc_pkg::CMD_FN1}, 1'b0, 1'b1, 16'h9C3E, 16'h4D27}};
	always #50 REF_CLK = ~REF_CLK;
	initial begin
		#2;
		forever #3 LINK_CLK = ~LINK_CLK;
	end
	htc_top #(.NORM_CYC(NC), .FAST_CYC(FC), .SERIAL_A(SA), .SERIAL_B(SB),
		.QUERY_RESP(QR)) htc_top_inst (
		.REF_CLK(REF_CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK),
		.SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
		.SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
		.TEMP_CODE(TEMP_CODE), .HUM_CODE(HUM_CODE), .HEATER_EN(HEATER_EN),
		.HEATER_LEVEL(HEATER_LEVEL), .CONV_BUSY(CONV_BUSY), .CONV_FAST(CONV_FAST)
	);
	htc_host htc_host_inst (.clk(REF_CLK), .scl(scl), .sda(sda), .scl_oe(h_scl_oe),
		.sda_oe(h_sda_oe));
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			num_errors++;
			$display("[ERR] at %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	function automatic logic [7:0] crc(input logic [15:0] d, input int n);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = n - 1; i >= 0; i--) begin
			c ^= d[8*i +: 8];
			for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ 8'h31) : (c << 1);
		end
		return c;
	endfunction : crc
	// n command bytes from the low end of b, top one first; heater writes also send a data byte after the code
	task automatic cmd(input logic [23:0] b, input int n, input logic p);
		logic ak;
		htc_host_inst.start();
		htc_host_inst.wbyte({htc_pkg::DEV_ADDR, 1'b0}, ak);
		chk(ak, 1);
		for (int i = n - 1; i >= 0; i--) begin
			htc_host_inst.wbyte(b[8*i +: 8], ak);
			chk(ak, 1);
		end
		if (p) htc_host_inst.stop();
	endtask : cmd
	task automatic rd(input int n, input logic [63:0] x);
		logic ak;
		logic [7:0] d;
		htc_host_inst.start();
		htc_host_inst.wbyte({htc_pkg::DEV_ADDR, 1'b1}, ak);
		chk(ak, 1);
		for (int i = 0; i < n; i++) begin
			htc_host_inst.rbyte(d, i < n - 1);
			chk(d, x[63 - 8*i -: 8]);
		end
		htc_host_inst.stop();
	endtask : rd
	task automatic probe(output logic ak);
		htc_host_inst.start();
		htc_host_inst.wbyte({htc_pkg::DEV_ADDR, 1'b1}, ak);
		htc_host_inst.stop();
	endtask : probe
	initial begin
		repeat (11) @(negedge REF_CLK);
		chk({SCL_OE, SDA_OE, HEATER_EN, HEATER_LEVEL, CONV_BUSY}, 0);
		@(negedge REF_CLK);
		RESETN = 1'b1;
		repeat (4) @(negedge REF_CLK);
		foreach (ht[i]) begin
			cmd({8'h00, htc_pkg::CMD_HWR, ht[i][20:13]}, 2, 1'b1);
			repeat (4) @(negedge REF_CLK);
			chk(HEATER_EN, ht[i][12]);
			chk(HEATER_LEVEL, ht[i][11:8]);
			cmd({16'h0000, htc_pkg::CMD_HRD}, 1, i[0]);
			rd(2, {ht[i][7:0], FF, 48'h0});
		end
		// a foreign address must leave the heater alone
		htc_host_inst.start();
		htc_host_inst.wbyte({7'h71, 1'b0}, a);
		chk(a, 0);
		htc_host_inst.wbyte(htc_pkg::CMD_HWR, a);
		htc_host_inst.wbyte(8'h1F, a);
		htc_host_inst.stop();
		repeat (4) @(negedge REF_CLK);
		chk({HEATER_EN, HEATER_LEVEL}, 0);
		foreach (mt[i]) begin
			TEMP_CODE = mt[i].t;
			HUM_CODE = mt[i].h;
			htc_host_inst.maxst = 0;
			cmd({8'h00, mt[i].c}, 2, mt[i].fast);
			repeat (5) @(negedge REF_CLK);
			chk({CONV_BUSY, CONV_FAST}, {1'b1, mt[i].fast});
			if (!mt[i].hold) begin
				probe(a);
				chk(a, 0);
				for (int k = 0; k < 2000 && CONV_BUSY !== 1'b0; k++) @(negedge REF_CLK);
				repeat (40) @(negedge REF_CLK);
				chk(CONV_BUSY, 0);
				htc_host_inst.maxst = 0;
			end
			e = {mt[i].t, crc(mt[i].t, 2), mt[i].h, crc(mt[i].h, 2), 16'h0000};
			rd(6, e);
			w = mt[i].hold ? (mt[i].fast ? FC : NC) : 0;
			chk(htc_host_inst.maxst + 80 >= w && htc_host_inst.maxst <= w + 20, 1);
		end
		cmd({8'h00, htc_pkg::CMD_ESNA0, htc_pkg::CMD_ESNA1}, 2, 1'b1);
		for (int k = 0; k < 4; k++) e[63 - 16*k -: 16] = {SA[31 - 8*k -: 8],
			crc({8'h00, SA[31 - 8*k -: 8]}, 1)};
		rd(8, e);
		cmd({8'h00, htc_pkg::CMD_ESNB0, htc_pkg::CMD_ESNB1}, 2, 1'b0);
		rd(7, {SB[31:16], crc(SB[31:16], 2), SB[15:0], crc(SB[15:0], 2), FF, 8'h00});
		cmd({8'h00, htc_pkg::CMD_Q20, htc_pkg::CMD_Q21}, 2, 1'b0);
		rd(4, {QR, FF, 32'h0});
		cmd({8'h00, htc_pkg::CMD_Q10, htc_pkg::CMD_Q11}, 2, 1'b1);
		rd(1, {FF, 56'h0});
		// soft reset in mid-conversion with the heater running
		cmd({8'h00, htc_pkg::CMD_HWR, 8'h1A}, 2, 1'b1);
		cmd({8'h00, htc_pkg::CMD_NN0, htc_pkg::CMD_NN1}, 2, 1'b1);
		chk({CONV_BUSY, HEATER_EN}, 2'h3);
		cmd({16'h0000, htc_pkg::CMD_SRST}, 1, 1'b1);
		repeat (10) @(negedge REF_CLK);
		chk({HEATER_EN, HEATER_LEVEL, CONV_BUSY}, 0);
		rd(1, {FF, 56'h0});
		// a second pin reset in mid-conversion with the heater running
		cmd({8'h00, htc_pkg::CMD_HWR, 8'h1A}, 2, 1'b1);
		cmd({8'h00, htc_pkg::CMD_FN0, htc_pkg::CMD_FN1}, 2, 1'b1);
		RESETN = 1'b0;
		repeat (12) @(negedge REF_CLK);
		chk({SCL_OE, SDA_OE, HEATER_EN, HEATER_LEVEL, CONV_BUSY}, 0);
		RESETN = 1'b1;
		repeat (4) @(negedge REF_CLK);
		cmd({16'h0000, htc_pkg::CMD_HRD}, 1, 1'b0);
		rd(1, {3'h0, htc_pkg::HTR_RST, 56'h0});
		print_verdict();
	end
	// about five times the expected length of the run
	initial begin
		#3_000_000;
		num_errors++;
		print_verdict();
	end
endmodule : htc_top_tb

// ---- hw/htc_fifo.sv ----
// synchronous response byte fifo with flush
`timescale 1ns/1ns
module htc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	initial begin
		if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
	end
	logic [W-1:0] mem [D];
	logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic wr, rd;
	assign in_ready = (wp_ff - rp_ff) != (AW+1)'(D);
	assign out_valid = wp_ff != rp_ff;
	assign out_data = mem[rp_ff[AW-1:0]];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	always_comb begin
		nxt_wp = flush ? '0 : wp_ff + (AW+1)'(wr);
		nxt_rp = flush ? '0 : rp_ff + (AW+1)'(rd);
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
		end
	end
	always_ff @(posedge clk) begin
		if (wr) begin
			mem[wp_ff[AW-1:0]] <= in_data;
		end
	end
endmodule : htc_fifo

// ---- hw/htc_pkg.sv ----
// shared constants and types of the humidity/temperature command port
package htc_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h70;
	localparam logic [7:0] CMD_ESNA0 = 8'hFA;
	localparam logic [7:0] CMD_ESNA1 = 8'h0F;
	localparam logic [7:0] CMD_ESNB0 = 8'hFC;
	localparam logic [7:0] CMD_ESNB1 = 8'hC9;
	localparam logic [7:0] CMD_SRST = 8'hFE;
	localparam logic [7:0] CMD_NH0 = 8'h7C;
	localparam logic [7:0] CMD_NH1 = 8'hA2;
	localparam logic [7:0] CMD_NN0 = 8'h78;
	localparam logic [7:0] CMD_NN1 = 8'h66;
	localparam logic [7:0] CMD_FH0 = 8'h64;
	localparam logic [7:0] CMD_FH1 = 8'h58;
	localparam logic [7:0] CMD_FN0 = 8'h60;
	localparam logic [7:0] CMD_FN1 = 8'h9C;
	localparam logic [7:0] CMD_Q10 = 8'h80;
	localparam logic [7:0] CMD_Q11 = 8'h5D;
	localparam logic [7:0] CMD_Q20 = 8'hEF;
	localparam logic [7:0] CMD_Q21 = 8'hC8;
	localparam logic [7:0] CMD_HWR = 8'hE6;
	localparam logic [7:0] CMD_HRD = 8'hE7;
	localparam int HTR_EN_POS = 4;
	localparam int HTR_LVL_W = 4;
	localparam logic [4:0] HTR_RST = 5'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam int CLK_MHZ = 10;
	localparam int NORM_US = 12000;
	localparam int FAST_US = 3000;
	localparam int NORM_CYC = NORM_US * CLK_MHZ;
	localparam int FAST_CYC = FAST_US * CLK_MHZ;
	typedef enum logic [2:0] {
		K_NONE, K_ESNA, K_ESNB, K_MEAS, K_QRY, K_HTR
	} htc_kind_t;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01, S_ADDR = 7'h02, S_AACK = 7'h04, S_WR = 7'h08,
		S_WACK = 7'h10, S_LOAD = 7'h20, S_RD = 7'h40
	} htc_st_t;
	localparam logic [6:0] S_RACK_CODE = 7'h00;
endpackage : htc_pkg

// ---- hw/htc_top.sv ----
// humidity/temperature sensor i2c target command port
// Overview of operation
// - answer only target address 0x70
// - two identifier commands, checksum after each byte (first) or after pairs (second)
// - normal conversion, hold and no-hold codes
// - fast conversion, hold and no-hold codes
// - first query acked, no effect
// - second query returns fixed three bytes
// - heater register write and read commands
// - stop before read keeps the transaction
// - hold mode stretches clock during conversion
// - no-hold: temperature bytes then checksum
// - no-hold nacks read address while converting
// - humidity bytes, checksum, host nack, stop
// - heater read returns one byte only
// - heater bit four switches heater
// - low four bits select heater current
`timescale 1ns/1ns
module htc_top #(
	parameter int NORM_CYC = htc_pkg::NORM_CYC,
	parameter int FAST_CYC = htc_pkg::FAST_CYC,
	parameter logic [31:0] SERIAL_A = 32'h0102_0304, // arbitrary
	parameter logic [31:0] SERIAL_B = 32'h0506_0708, // arbitrary
	parameter logic [23:0] QUERY_RESP = 24'h11_22_33 // arbitrary
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic LINK_CLK,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [15:0] TEMP_CODE,
	input wire logic [15:0] HUM_CODE,
	output logic HEATER_EN,
	output logic [3:0] HEATER_LEVEL,
	output logic CONV_BUSY,
	output logic CONV_FAST
);
	initial begin
		if (NORM_CYC < 1 || FAST_CYC < 1 || NORM_CYC >= 2**24 || FAST_CYC >= 2**24)
			$error("conversion counts out of range");
	end
	function automatic logic [7:0] crc(input logic [15:0] d, input logic two);
		logic [7:0] c;
		c = htc_pkg::CRC_INIT;
		for (int i = 0; i < 16; i++) begin
			if (two || i >= 8) begin
				c = (c[7] ^ d[15-i]) ? {c[6:0], 1'b0} ^ htc_pkg::CRC_POLY : {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : crc

	// core domain: conversion timer and result
	logic [2:0] req_s_ff, abt_s_ff;
	logic busy_ff, nxt_busy, fastc_ff, nxt_fastc, done_ff, nxt_done;
	logic [23:0] cnt_ff, nxt_cnt;
	logic [15:0] temp_ff, nxt_temp, hum_ff, nxt_hum;
	logic req_ff, abt_ff, fast_ff;
	always_comb begin
		nxt_busy = busy_ff;
		nxt_fastc = fastc_ff;
		nxt_done = done_ff;
		nxt_cnt = cnt_ff;
		nxt_temp = temp_ff;
		nxt_hum = hum_ff;
		if (abt_s_ff[2] ^ abt_s_ff[1]) begin
			nxt_busy = 1'b0;
			nxt_done = req_s_ff[1];
		end else if (req_s_ff[2] ^ req_s_ff[1]) begin
			nxt_busy = 1'b1;
			nxt_fastc = fast_ff; // held steady since the request toggled
			nxt_cnt = fast_ff ? 24'(FAST_CYC - 1) : 24'(NORM_CYC - 1);
		end else if (busy_ff) begin
			nxt_cnt = cnt_ff - 24'h000001;
			if (cnt_ff == 24'h000000) begin
				nxt_busy = 1'b0;
				nxt_temp = TEMP_CODE;
				nxt_hum = HUM_CODE;
				nxt_done = req_s_ff[1];
			end
		end
	end
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			req_s_ff <= 3'h0;
			abt_s_ff <= 3'h0;
			busy_ff <= 1'b0;
			fastc_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= 24'h000000;
			temp_ff <= 16'h0000;
			hum_ff <= 16'h0000;
		end else begin
			req_s_ff <= {req_s_ff[1:0], req_ff};
			abt_s_ff <= {abt_s_ff[1:0], abt_ff};
			busy_ff <= nxt_busy;
			fastc_ff <= nxt_fastc;
			done_ff <= nxt_done;
			cnt_ff <= nxt_cnt;
			temp_ff <= nxt_temp;
			hum_ff <= nxt_hum;
		end
	end
	assign CONV_BUSY = busy_ff;
	assign CONV_FAST = fastc_ff;

	// link domain: i2c target
	logic [1:0] lrst_ff;
	logic lrst_n;
	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN) begin
			lrst_ff <= 2'h0;
		end else begin
			lrst_ff <= {lrst_ff[0], 1'b1};
		end
	end
	assign lrst_n = lrst_ff[1];
	logic [2:0] scl_ff, sda_ff;
	logic [1:0] done_s_ff;
	always_ff @(posedge LINK_CLK or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_ff <= 3'h7;
			sda_ff <= 3'h7;
			done_s_ff <= 2'h0;
		end else begin
			scl_ff <= {scl_ff[1:0], SCL_IN};
			sda_ff <= {sda_ff[1:0], SDA_IN};
			done_s_ff <= {done_s_ff[0], done_ff};
		end
	end
	logic scl_r, scl_f, start_c, stop_c, sda, busy_l;
	assign sda = sda_ff[1];
	assign scl_r = scl_ff[1] && !scl_ff[2];
	assign scl_f = !scl_ff[1] && scl_ff[2];
	assign start_c = scl_ff[1] && scl_ff[2] && sda_ff[2] && !sda_ff[1];
	assign stop_c = scl_ff[1] && scl_ff[2] && !sda_ff[2] && sda_ff[1];
	assign busy_l = req_ff ^ done_s_ff[1];

	htc_pkg::htc_st_t st_ff, nxt_st;
	htc_pkg::htc_kind_t kind_ff, nxt_kind;
	logic [7:0] sh_ff, nxt_sh, cmd0_ff, nxt_cmd0, rbyte, fbyte;
	logic [2:0] bcnt_ff, nxt_bcnt, idx_ff, nxt_idx;
	logic [1:0] wcnt_ff, nxt_wcnt;
	logic [4:0] htr_ff, nxt_htr;
	logic [3:0] rlen;
	logic hold_ff, nxt_hold, nxt_fast, nxt_req, nxt_abt, rack_ff, nxt_rack;
	logic sda_oe_ff, nxt_sda_oe, scl_oe_ff, nxt_scl_oe;
	logic push, pop, flush, f_rdy, f_val, match;
	logic [7:0] f_out;
	assign match = sh_ff[7:1] == htc_pkg::DEV_ADDR;
	assign fbyte = f_val ? f_out : htc_pkg::IDLE_BYTE;

	always_comb begin
		rbyte = 8'h00;
		rlen = 4'h0;
		unique case (kind_ff)
			htc_pkg::K_MEAS: begin
				rlen = 4'h6;
				unique case (idx_ff)
					3'h0: rbyte = temp_ff[15:8];
					3'h1: rbyte = temp_ff[7:0];
					3'h2: rbyte = crc(temp_ff, 1'b1);
					3'h3: rbyte = hum_ff[15:8];
					3'h4: rbyte = hum_ff[7:0];
					default: rbyte = crc(hum_ff, 1'b1);
				endcase
			end
			htc_pkg::K_ESNA: begin
				rlen = 4'h8;
				rbyte = SERIAL_A[5'h1F - {idx_ff[2:1], 3'h0} -: 8];
				if (idx_ff[0]) rbyte = crc({8'h00, rbyte}, 1'b0);
			end
			htc_pkg::K_ESNB: begin
				rlen = 4'h6;
				unique case (idx_ff)
					3'h0: rbyte = SERIAL_B[31:24];
					3'h1: rbyte = SERIAL_B[23:16];
					3'h2: rbyte = crc(SERIAL_B[31:16], 1'b1);
					3'h3: rbyte = SERIAL_B[15:8];
					3'h4: rbyte = SERIAL_B[7:0];
					default: rbyte = crc(SERIAL_B[15:0], 1'b1);
				endcase
			end
			htc_pkg::K_QRY: begin
				rlen = 4'h3;
				rbyte = QUERY_RESP[5'h17 - {idx_ff[1:0], 3'h0} -: 8];
			end
			htc_pkg::K_HTR: begin
				rlen = 4'h1; // no checksum after the register byte
				rbyte = {3'h0, htr_ff};
			end
			default: rlen = 4'h0;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_kind = kind_ff;
		nxt_sh = sh_ff;
		nxt_cmd0 = cmd0_ff;
		nxt_bcnt = bcnt_ff;
		nxt_idx = idx_ff;
		nxt_wcnt = wcnt_ff;
		nxt_htr = htr_ff;
		nxt_hold = hold_ff;
		nxt_fast = fast_ff;
		nxt_req = req_ff;
		nxt_abt = abt_ff;
		nxt_rack = rack_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_scl_oe = scl_oe_ff;
		push = 1'b0;
		pop = 1'b0;
		flush = 1'b0;
		if (start_c) begin
			nxt_st = htc_pkg::S_ADDR;
			nxt_bcnt = 3'h0;
			nxt_sda_oe = 1'b0;
		end else if (stop_c) begin
			nxt_st = htc_pkg::S_IDLE; // response kind survives the stop
			nxt_sda_oe = 1'b0;
			nxt_scl_oe = 1'b0;
		end else begin
			unique case (st_ff)
				htc_pkg::S_IDLE: nxt_sda_oe = 1'b0;
				htc_pkg::S_ADDR, htc_pkg::S_WR: if (scl_r) begin
					nxt_sh = {sh_ff[6:0], sda};
					nxt_bcnt = bcnt_ff + 3'h1;
					if (bcnt_ff == 3'h7) nxt_st = (st_ff == htc_pkg::S_ADDR) ? htc_pkg::S_AACK
						: htc_pkg::S_WACK;
				end
				htc_pkg::S_AACK: if (scl_f) begin
					if (!sda_oe_ff) begin
						if (match && !(sh_ff[0] && kind_ff == htc_pkg::K_MEAS && busy_l
							&& !hold_ff)) nxt_sda_oe = 1'b1;
						else nxt_st = htc_pkg::S_IDLE;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_bcnt = 3'h0;
						if (sh_ff[0]) begin
							nxt_scl_oe = 1'b1;
							flush = 1'b1;
							nxt_idx = 3'h0;
							nxt_rack = 1'b0; // a read cut short may leave the flag set
							nxt_st = htc_pkg::S_LOAD;
						end else begin
							nxt_wcnt = 2'h0;
							nxt_st = htc_pkg::S_WR;
						end
					end
				end
				htc_pkg::S_WACK: if (scl_f) begin
					if (sda_oe_ff) begin
						nxt_sda_oe = 1'b0;
						nxt_bcnt = 3'h0;
						nxt_st = htc_pkg::S_WR;
					end else begin
						nxt_sda_oe = 1'b1; // every command byte is acked
						if (wcnt_ff == 2'h0) begin
							nxt_cmd0 = sh_ff;
							nxt_wcnt = 2'h1;
							nxt_kind = (sh_ff == htc_pkg::CMD_HRD) ? htc_pkg::K_HTR
								: htc_pkg::K_NONE;
							if (sh_ff == htc_pkg::CMD_SRST) begin
								nxt_htr = htc_pkg::HTR_RST;
								nxt_abt = !abt_ff;
							end
						end else if (wcnt_ff == 2'h1) begin
							nxt_wcnt = 2'h2;
							if (cmd0_ff == htc_pkg::CMD_HWR) nxt_htr = sh_ff[4:0];
							unique case ({cmd0_ff, sh_ff})
								{htc_pkg::CMD_ESNA0, htc_pkg::CMD_ESNA1}: nxt_kind = htc_pkg::K_ESNA;
								{htc_pkg::CMD_ESNB0, htc_pkg::CMD_ESNB1}: nxt_kind = htc_pkg::K_ESNB;
								{htc_pkg::CMD_Q20, htc_pkg::CMD_Q21}: nxt_kind = htc_pkg::K_QRY;
								{htc_pkg::CMD_Q10, htc_pkg::CMD_Q11}: nxt_kind = htc_pkg::K_NONE;
								{htc_pkg::CMD_NH0, htc_pkg::CMD_NH1},
								{htc_pkg::CMD_NN0, htc_pkg::CMD_NN1},
								{htc_pkg::CMD_FH0, htc_pkg::CMD_FH1},
								{htc_pkg::CMD_FN0, htc_pkg::CMD_FN1}: begin
									nxt_kind = htc_pkg::K_MEAS;
									nxt_hold = cmd0_ff[2]; // hold codes have bit 2 set
									nxt_fast = !cmd0_ff[4];
									nxt_req = !req_ff;
								end
								default: ;
							endcase
						end
					end
				end
				htc_pkg::S_LOAD: begin
					nxt_scl_oe = 1'b1;
					if (kind_ff == htc_pkg::K_MEAS && busy_l) nxt_idx = idx_ff;
					else if (!rack_ff && {1'b0, idx_ff} != rlen) begin
						// a flag, not the index, ends an 8-byte load: the index wraps to zero
						if (f_rdy) begin
							push = 1'b1;
							nxt_idx = idx_ff + 3'h1;
							if ({1'b0, idx_ff} == rlen - 4'h1) nxt_rack = 1'b1;
						end
					end else begin
						pop = f_val;
						nxt_rack = 1'b0;
						nxt_sh = fbyte;
						nxt_sda_oe = !fbyte[7];
						nxt_st = htc_pkg::S_RD;
					end
				end
				htc_pkg::S_RD: begin
					nxt_scl_oe = 1'b0; // released a cycle after sda so the first bit has setup
					if (scl_f && nxt_sda_oe == sda_oe_ff && rack_ff) begin
						nxt_rack = 1'b0; // scl fall ending the ack slot
						nxt_sh = fbyte;
						pop = f_val;
						nxt_sda_oe = !fbyte[7];
					end else if (scl_r && rack_ff) begin
						if (sda) begin
							nxt_st = htc_pkg::S_IDLE; // host nack ends the read
							nxt_kind = htc_pkg::K_NONE;
							nxt_rack = 1'b0;
						end
					end else if (scl_f) begin
						if (bcnt_ff == 3'h7) begin
							nxt_sda_oe = 1'b0;
							nxt_rack = 1'b1;
							nxt_bcnt = 3'h0;
						end else begin
							nxt_sh = {sh_ff[6:0], 1'b1};
							nxt_sda_oe = !sh_ff[6];
							nxt_bcnt = bcnt_ff + 3'h1;
						end
					end
				end
				default: nxt_st = htc_pkg::S_IDLE;
			endcase
		end
	end

	always_ff @(posedge LINK_CLK or negedge lrst_n) begin
		if (!lrst_n) begin
			st_ff <= htc_pkg::S_IDLE;
			kind_ff <= htc_pkg::K_NONE;
			sh_ff <= 8'h00;
			cmd0_ff <= 8'h00;
			bcnt_ff <= 3'h0;
			idx_ff <= 3'h0;
			wcnt_ff <= 2'h0;
			htr_ff <= htc_pkg::HTR_RST;
			hold_ff <= 1'b0;
			fast_ff <= 1'b0;
			req_ff <= 1'b0;
			abt_ff <= 1'b0;
			rack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			kind_ff <= nxt_kind;
			sh_ff <= nxt_sh;
			cmd0_ff <= nxt_cmd0;
			bcnt_ff <= nxt_bcnt;
			idx_ff <= nxt_idx;
			wcnt_ff <= nxt_wcnt;
			htr_ff <= nxt_htr;
			hold_ff <= nxt_hold;
			fast_ff <= nxt_fast;
			req_ff <= nxt_req;
			abt_ff <= nxt_abt;
			rack_ff <= nxt_rack;
			sda_oe_ff <= nxt_sda_oe;
			scl_oe_ff <= nxt_scl_oe;
		end
	end
	assign SDA_OE = sda_oe_ff;
	assign SCL_OE = scl_oe_ff;
	assign SDA_OUT = 1'b0;
	assign SCL_OUT = 1'b0;
	assign HEATER_EN = htr_ff[htc_pkg::HTR_EN_POS];
	assign HEATER_LEVEL = htr_ff[htc_pkg::HTR_LVL_W-1:0];

	htc_fifo #(.W(8), .D(8)) htc_fifo_inst (
		.clk(LINK_CLK),
		.rst_n(lrst_n),
		.flush(flush),
		.in_valid(push),
		.in_ready(f_rdy),
		.in_data(rbyte),
		.out_valid(f_val),
		.out_ready(pop),
		.out_data(f_out)
	);

	default clocking cb @(posedge LINK_CLK); endclocking
	default disable iff (!lrst_n);
	addr_nack_a: assert property ((st_ff == htc_pkg::S_AACK && sda_oe_ff) |-> match)
		else $error("ack driven for foreign address");
	nohold_nack_a: assert property ((st_ff == htc_pkg::S_AACK && scl_f && !sda_oe_ff
		&& sh_ff[0] && kind_ff == htc_pkg::K_MEAS && busy_l && !hold_ff)
		|=> !sda_oe_ff && st_ff == htc_pkg::S_IDLE)
		else $error("read address acked during no-hold conversion");
	hold_stretch_a: assert property (
		(st_ff == htc_pkg::S_LOAD && busy_l) |-> scl_oe_ff)
		else $error("clock not held during conversion");
	srst_heater_a: assert property ((st_ff == htc_pkg::S_WACK && scl_f && !sda_oe_ff
		&& wcnt_ff == 2'h0 && sh_ff == htc_pkg::CMD_SRST) |=> htr_ff == htc_pkg::HTR_RST)
		else $error("soft reset left heater set");
	htr_write_a: assert property ((st_ff == htc_pkg::S_WACK && scl_f && !sda_oe_ff
		&& wcnt_ff == 2'h1 && cmd0_ff == htc_pkg::CMD_HWR)
		|=> ##1 HEATER_LEVEL == $past(sh_ff[3:0], 2))
		else $error("heater write lost");
	htr_len_a: assert property ((st_ff == htc_pkg::S_LOAD
		&& kind_ff == htc_pkg::K_HTR && nxt_st == htc_pkg::S_RD) |-> idx_ff == 3'h1)
		else $error("heater read length wrong");
	meas_len_a: assert property ((st_ff == htc_pkg::S_LOAD
		&& kind_ff == htc_pkg::K_MEAS && nxt_st == htc_pkg::S_RD) |-> idx_ff == 3'h6)
		else $error("measurement response length wrong");
	query_a: assert property ((st_ff == htc_pkg::S_WACK && scl_f && !sda_oe_ff
		&& wcnt_ff == 2'h1 && {cmd0_ff, sh_ff} == {htc_pkg::CMD_Q10, htc_pkg::CMD_Q11})
		|=> kind_ff == htc_pkg::K_NONE && $stable(htr_ff))
		else $error("first query had an effect");
	fifo_ovf_a: assert property (push |-> f_rdy) else $error("fifo overflow");
	result_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(!busy_ff && !$past(busy_ff)) |-> $stable(temp_ff) && $stable(hum_ff))
		else $error("result changed while idle");
	hold_c: cover property (st_ff == htc_pkg::S_LOAD && busy_l && hold_ff);
	nack_c: cover property (st_ff == htc_pkg::S_AACK && scl_f && !sda_oe_ff && busy_l && !hold_ff);
	esn_c: cover property (st_ff == htc_pkg::S_LOAD && kind_ff == htc_pkg::K_ESNA && idx_ff == 3'h7);
	htr_c: cover property (HEATER_EN);
endmodule : htc_top
